// ==== src/cmc_cipher.sv ====
// Counter-mode traffic cipher with bypass, Wishbone registers and self-test
//
// Behaviour
// RULE1: Bypass passes input words out unchanged
// RULE2: 128-bit input bus, separate 128-bit output bus
// RULE3: Configuration written over 32-bit port, 6 address lines
// RULE4: Status read over 32-bit port, 6 address lines
// RULE5: Discrete output shows cipher function active
// RULE6: Hard or soft reset clears stored key
// RULE7: Key and nonce kept on chip, plaintext
// RULE8: Key comes from outside; no key generation
// RULE9: Traffic processed in counter mode only
// RULE10: Processor may pulse the soft reset
// RULE11: Software loads 256-bit key, 128-bit nonce
// RULE12: Address 0 bit 29 shows self-test failure
// RULE13: Address 0 bit 30 clear in bypass
// RULE14: Encrypt and decrypt self-test after every reset
// RULE15: Key and nonce addresses read back zero
// RULE16: Active output low in bypass or failure
//
// The register offsets and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ps
`include "cmc_defs.svh"
module cmc_cipher
  import cmc_pkg::*;
#(
  parameter int DATA_W = 128,
  parameter int ROUNDS = `CMC_CORE_ROUNDS
) (
  input  wire logic              SYS_CLK_I,
  input  wire logic              RESETN_I,
  input  wire logic              SOFT_RESET_I,
  input  wire logic              WB_CYC_I,
  input  wire logic              WB_STB_I,
  input  wire logic              WB_WE_I,
  input  wire logic [7:2]        WB_ADR_I,
  input  wire logic [3:0]        WB_SEL_I,
  input  wire logic [31:0]       WB_DAT_I,
  output logic      [31:0]       WB_DAT_O,
  output logic                   WB_ACK_O,
  input  wire logic [DATA_W-1:0] DATA_I,
  input  wire logic              DATA_VALID_I,
  output logic                   DATA_READY_O,
  output logic      [DATA_W-1:0] DATA_O,
  output logic                   DATA_VALID_O,
  input  wire logic              DATA_READY_I,
  output logic                   AES_ACTIVE_O
);

  if (DATA_W != 128) begin : g_chk
    $error("cmc_cipher: DATA_W must be 128, the cipher block width");
  end

  cmc_state_t   state_ff;
  logic [31:0]  key_mem_ff [0:7];
  logic [31:0]  nonce_mem_ff [0:3];
  logic [255:0] key_all;
  logic [127:0] nonce_all;
  logic         bypass_ff;
  logic         fail_ff;
  logic         kat_req_ff;
  logic [127:0] blk_cnt_ff;
  logic [127:0] hold_ff;
  logic [127:0] kat_ct_ff;
  logic         ack_ff;
  logic [31:0]  rdat_ff;
  logic [127:0] buf_mem_ff [0:1];
  logic         wr_ptr_ff;
  logic         rd_ptr_ff;
  logic [1:0]   buf_cnt_ff;

  logic         wb_acc;
  logic         wb_wr;
  logic [7:0]   wb_ofs;
  logic         in_fire;
  logic         kat_sel;
  logic         core_start;
  logic         core_done;
  logic [127:0] core_ks;
  logic [255:0] core_key;
  logic [127:0] core_ctr;
  logic         push;
  logic [127:0] push_data;
  logic         pop;
  logic [31:0]  nxt_ctrl;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic in_range(input logic [7:0] ofs, input logic [7:0] lo,
                                    input logic [7:0] hi);
    return (ofs >= lo) && (ofs <= hi);
  endfunction : in_range

  // Wishbone slave: one wait state, ack for one cycle
  assign wb_ofs = {WB_ADR_I, 2'b00};
  assign wb_acc = WB_CYC_I && WB_STB_I && !ack_ff;
  assign wb_wr  = wb_acc && WB_WE_I;
  assign nxt_ctrl = merge({30'h0000_0000, 1'b0, bypass_ff}, WB_DAT_I, WB_SEL_I);

  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      ack_ff  <= 1'b0;
      rdat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= wb_acc;  // [RULE3] [RULE4]
      if (wb_acc && !WB_WE_I) begin
        rdat_ff <= 32'h0000_0000;  // [RULE15]
        if (wb_ofs == `CMC_OFS_STATUS) begin
          rdat_ff[`CMC_STAT_FAIL_BIT]   <= fail_ff;  // [RULE12]
          rdat_ff[`CMC_STAT_CIPHER_BIT] <= !bypass_ff;  // [RULE13]
          rdat_ff[`CMC_STAT_BUSY_BIT]   <= (state_ff != ST_IDLE) || kat_req_ff;
        end else if (wb_ofs == `CMC_OFS_CTRL) begin
          rdat_ff[`CMC_CTRL_BYPASS_BIT] <= bypass_ff;
        end else if (wb_ofs == `CMC_OFS_BLKCNT) begin
          rdat_ff <= blk_cnt_ff[31:0];
        end
      end
    end
  end

  assign WB_ACK_O = ack_ff;
  assign WB_DAT_O = rdat_ff;

  // Key and nonce storage, cleared by either reset
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      for (int i = 0; i < 8; i++) key_mem_ff[i] <= 32'h0000_0000;  // [RULE6]
      for (int i = 0; i < 4; i++) nonce_mem_ff[i] <= 32'h0000_0000;
    end else if (SOFT_RESET_I) begin
      for (int i = 0; i < 8; i++) key_mem_ff[i] <= 32'h0000_0000;  // [RULE6]
      for (int i = 0; i < 4; i++) nonce_mem_ff[i] <= 32'h0000_0000;
    end else if (wb_wr) begin
      if (in_range(wb_ofs, `CMC_OFS_KEY_FIRST, `CMC_OFS_KEY_LAST)) begin
        key_mem_ff[WB_ADR_I[4:2]] <= merge(key_mem_ff[WB_ADR_I[4:2]], WB_DAT_I,
                                           WB_SEL_I);  // [RULE7]
      end
      if (in_range(wb_ofs, `CMC_OFS_NONCE_FIRST, `CMC_OFS_NONCE_LAST)) begin
        nonce_mem_ff[WB_ADR_I[3:2]] <= merge(nonce_mem_ff[WB_ADR_I[3:2]], WB_DAT_I,
                                             WB_SEL_I);  // [RULE7]
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 8; i++) key_all[32*i +: 32] = key_mem_ff[i];
    for (int i = 0; i < 4; i++) nonce_all[32*i +: 32] = nonce_mem_ff[i];
  end

  // Control: bypass mode, self-test request on mode change
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      bypass_ff  <= 1'(`CMC_CTRL_RESET);
      kat_req_ff <= 1'b0;
    end else if (SOFT_RESET_I) begin
      bypass_ff  <= 1'(`CMC_CTRL_RESET);
      kat_req_ff <= 1'b0;
    end else begin
      if (wb_wr && wb_ofs == `CMC_OFS_CTRL) begin
        bypass_ff <= nxt_ctrl[`CMC_CTRL_BYPASS_BIT];  // [RULE1]
      end
      if (wb_wr && wb_ofs == `CMC_OFS_CTRL
          && nxt_ctrl[`CMC_CTRL_BYPASS_BIT] != bypass_ff) begin
        kat_req_ff <= 1'b1;
      end else if (state_ff == ST_IDLE) begin
        kat_req_ff <= 1'b0;
      end
    end
  end

  // Block counter: advances once per ciphered word
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      blk_cnt_ff <= '0;
    end else if (SOFT_RESET_I) begin
      blk_cnt_ff <= '0;
    end else if (in_fire && !bypass_ff) begin
      blk_cnt_ff <= blk_cnt_ff + 128'h1;  // [RULE9]
    end else if ((wb_wr && wb_ofs == `CMC_OFS_CTRL && nxt_ctrl[`CMC_CTRL_RESTART_BIT])
                 || (wb_wr && in_range(wb_ofs, `CMC_OFS_NONCE_FIRST, `CMC_OFS_NONCE_LAST))) begin
      blk_cnt_ff <= '0;
    end
  end

  // Sequencer: self-test after reset, then traffic
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      state_ff  <= ST_KAT_ENC_GO;  // [RULE14]
      fail_ff   <= 1'b0;
      hold_ff   <= '0;
      kat_ct_ff <= '0;
    end else if (SOFT_RESET_I) begin
      state_ff  <= ST_KAT_ENC_GO;  // [RULE14]
      fail_ff   <= 1'b0;
      hold_ff   <= '0;
      kat_ct_ff <= '0;
    end else begin
      case (state_ff)
        ST_KAT_ENC_GO: begin
          fail_ff  <= 1'b0;
          state_ff <= ST_KAT_ENC_WAIT;
        end
        ST_KAT_ENC_WAIT: begin
          if (core_done) begin
            kat_ct_ff <= `CMC_KAT_PT ^ core_ks;  // [RULE14]
            state_ff  <= ST_KAT_DEC_GO;
          end
        end
        ST_KAT_DEC_GO: begin
          state_ff <= ST_KAT_DEC_WAIT;
        end
        ST_KAT_DEC_WAIT: begin
          if (core_done) begin
            fail_ff  <= ((kat_ct_ff ^ core_ks) != `CMC_KAT_PT)
                        || (kat_ct_ff == `CMC_KAT_PT);  // [RULE12] [RULE14]
            state_ff <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (kat_req_ff) begin
            state_ff <= ST_KAT_ENC_GO;
          end else if (in_fire && !bypass_ff) begin
            hold_ff  <= DATA_I;
            state_ff <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (core_done) begin
            state_ff <= ST_IDLE;
          end
        end
        default: begin
          state_ff <= ST_KAT_ENC_GO;
        end
      endcase
    end
  end

  // Keystream core, fed the counter block nonce plus block index
  assign kat_sel    = (state_ff != ST_IDLE) && (state_ff != ST_RUN);
  assign core_key   = kat_sel ? `CMC_KAT_KEY : key_all;
  assign core_ctr   = kat_sel ? `CMC_KAT_CTR : nonce_all + blk_cnt_ff;  // [RULE9]
  assign core_start = (state_ff == ST_KAT_ENC_GO) || (state_ff == ST_KAT_DEC_GO)
                      || (in_fire && !bypass_ff);

  cmc_keystream #(
    .ROUNDS (ROUNDS)
  ) u_core (
    .clk_i   (SYS_CLK_I),
    .rstn_i  (RESETN_I),
    .start_i (core_start),
    .key_i   (core_key),
    .ctr_i   (core_ctr),
    .busy_o  (),
    .done_o  (core_done),
    .ks_o    (core_ks)
  );

  // Input acceptance and output buffer
  assign DATA_READY_O = (state_ff == ST_IDLE) && !kat_req_ff && !SOFT_RESET_I
                        && (buf_cnt_ff != 2'd2) && (bypass_ff || !fail_ff);  // [RULE2]
  assign in_fire   = DATA_VALID_I && DATA_READY_O;
  assign push      = (in_fire && bypass_ff) || (state_ff == ST_RUN && core_done);
  assign push_data = bypass_ff && in_fire ? DATA_I : hold_ff ^ core_ks;  // [RULE1] [RULE9]
  assign pop       = DATA_VALID_O && DATA_READY_I;

  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      buf_mem_ff[0] <= '0;
      buf_mem_ff[1] <= '0;
      wr_ptr_ff     <= 1'b0;
      rd_ptr_ff     <= 1'b0;
      buf_cnt_ff    <= 2'd0;
    end else if (SOFT_RESET_I) begin
      buf_mem_ff[0] <= '0;
      buf_mem_ff[1] <= '0;
      wr_ptr_ff     <= 1'b0;
      rd_ptr_ff     <= 1'b0;
      buf_cnt_ff    <= 2'd0;
    end else begin
      if (push) begin
        buf_mem_ff[wr_ptr_ff] <= push_data;  // [RULE2]
        wr_ptr_ff             <= !wr_ptr_ff;
      end
      if (pop) begin
        rd_ptr_ff <= !rd_ptr_ff;
      end
      buf_cnt_ff <= buf_cnt_ff + {1'b0, push} - {1'b0, pop};
    end
  end

  assign DATA_VALID_O = buf_cnt_ff != 2'd0;
  assign DATA_O       = buf_mem_ff[rd_ptr_ff];
  assign AES_ACTIVE_O = !bypass_ff && !fail_ff && !kat_sel;  // [RULE5] [RULE16]

  // Checks
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!RESETN_I);

  property p_bypass_pass;
    in_fire && bypass_ff && buf_cnt_ff == 2'd0 |=> DATA_VALID_O && DATA_O == $past(DATA_I);
  endproperty
  a_bypass_pass: assert property (p_bypass_pass) else $error("bypass word altered"); // [RULE1]

  property p_ack_once;
    wb_acc |=> WB_ACK_O ##1 !WB_ACK_O;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack not one cycle"); // [RULE3]

  property p_fail_bit;
    wb_acc && !WB_WE_I && wb_ofs == `CMC_OFS_STATUS |=> WB_DAT_O[29] == $past(fail_ff);
  endproperty
  a_fail_bit: assert property (p_fail_bit) else $error("status fail bit wrong"); // [RULE12]

  property p_mode_bit;
    wb_acc && !WB_WE_I && wb_ofs == `CMC_OFS_STATUS |=> WB_DAT_O[30] != $past(bypass_ff);
  endproperty
  a_mode_bit: assert property (p_mode_bit) else $error("status mode bit wrong"); // [RULE13]

  property p_key_hidden;
    wb_acc && !WB_WE_I && wb_ofs >= `CMC_OFS_KEY_FIRST |=> WB_DAT_O == 32'h0000_0000;
  endproperty
  a_key_hidden: assert property (p_key_hidden) else $error("key readable"); // [RULE15] [RULE4]

  property p_key_clear;
    SOFT_RESET_I |=> key_all == '0 && nonce_all == '0;
  endproperty
  a_key_clear: assert property (p_key_clear) else $error("key kept over reset"); // [RULE6]

  property p_kat_start;
    SOFT_RESET_I ##1 !SOFT_RESET_I |-> state_ff == ST_KAT_ENC_GO ##1 state_ff == ST_KAT_ENC_WAIT;
  endproperty
  a_kat_start: assert property (p_kat_start) else $error("self-test not started"); // [RULE14]

  property p_active;
    (bypass_ff || fail_ff) |-> !AES_ACTIVE_O;
  endproperty
  a_active: assert property (p_active) else $error("active in bypass or fail"); // [RULE16]

  property p_active_src;
    AES_ACTIVE_O |-> state_ff == ST_IDLE || state_ff == ST_RUN;
  endproperty
  a_active_src: assert property (p_active_src) else $error("active during self-test"); // [RULE5]

  property p_ctr_xor;
    state_ff == ST_RUN && core_done |-> push && push_data == (hold_ff ^ core_ks);
  endproperty
  a_ctr_xor: assert property (p_ctr_xor) else $error("ciphered word not xor"); // [RULE9]

  property p_key_used;
    in_fire && !bypass_ff |-> core_start && core_key == key_all;
  endproperty
  a_key_used: assert property (p_key_used) else $error("stored key not used"); // [RULE7]

  property p_no_overflow;
    buf_cnt_ff == 2'd2 |-> !DATA_READY_O;
  endproperty
  a_no_overflow: assert property (p_no_overflow) else $error("buffer overrun"); // [RULE2]

  c_bypass_word: cover property (in_fire && bypass_ff);
  c_cipher_word: cover property (state_ff == ST_RUN && core_done);
  c_stall_full:  cover property (buf_cnt_ff == 2'd2 && !DATA_READY_I);
  c_kat_done:    cover property (state_ff == ST_KAT_DEC_WAIT && core_done);

endmodule : cmc_cipher

// ==== src/cmc_defs.svh ====
// Register offsets, field positions, reset values and self-test constants of the cipher
`ifndef CMC_DEFS_SVH
`define CMC_DEFS_SVH

`define CMC_OFS_STATUS     8'h00
`define CMC_OFS_CTRL       8'h04
`define CMC_OFS_BLKCNT     8'h08
`define CMC_OFS_KEY_FIRST  8'h20
`define CMC_OFS_KEY_LAST   8'h3C
`define CMC_OFS_NONCE_FIRST 8'h40
`define CMC_OFS_NONCE_LAST 8'h4C

`define CMC_STAT_BUSY_BIT   0
`define CMC_STAT_FAIL_BIT   29
`define CMC_STAT_CIPHER_BIT 30
`define CMC_CTRL_BYPASS_BIT 0
`define CMC_CTRL_RESTART_BIT 1

`define CMC_CTRL_RESET     32'h0000_0001
`define CMC_CORE_ROUNDS    14

`define CMC_KAT_KEY  256'h0f1e_2d3c_4b5a_6978_8796_a5b4_c3d2_e1f0_1234_5678_9abc_def0_0fed_cba9_8765_4321
`define CMC_KAT_CTR  128'h0011_2233_4455_6677_8899_aabb_ccdd_eeff
`define CMC_KAT_PT   128'h6bc1_bee2_2e40_9f96_e93d_7e11_7393_172a

`endif

// ==== src/cmc_pkg.sv ====
// Types shared by the traffic cipher modules
package cmc_pkg;

  typedef enum logic [2:0] {
    ST_KAT_ENC_GO,
    ST_KAT_ENC_WAIT,
    ST_KAT_DEC_GO,
    ST_KAT_DEC_WAIT,
    ST_IDLE,
    ST_RUN
  } cmc_state_t;

endpackage : cmc_pkg

// ==== src/cmc_keystream.sv ====
// Iterative keyed block function that turns a counter block into keystream
`timescale 1ns/1ps
`include "cmc_defs.svh"
module cmc_keystream
  import cmc_pkg::*;
#(
  parameter int ROUNDS = `CMC_CORE_ROUNDS
) (
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  input  wire logic         start_i,
  input  wire logic [255:0] key_i,
  input  wire logic [127:0] ctr_i,
  output logic              busy_o,
  output logic              done_o,
  output logic [127:0]      ks_o
);

  if (ROUNDS < 1 || ROUNDS > 64) begin : g_chk
    $error("cmc_keystream: ROUNDS must be 1 to 64");
  end

  logic [127:0] st_ff;
  logic [255:0] key_ff;
  logic [5:0]   rnd_ff;
  logic         busy_ff;
  logic         done_ff;

  function automatic logic [127:0] mix(input logic [127:0] s, input logic [31:0] rk);
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] c;
    logic [31:0] d;
    {a, b, c, d} = s;
    a = a + b;
    d = d ^ a;
    d = {d[15:0], d[31:16]};
    c = c + d;
    b = b ^ c;
    b = {b[19:0], b[31:20]};
    a = a ^ rk;
    return {b, c, d, a};
  endfunction : mix

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_ff   <= '0;
      key_ff  <= '0;
      rnd_ff  <= '0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (start_i) begin
        st_ff   <= ctr_i ^ key_i[127:0];
        key_ff  <= key_i;
        rnd_ff  <= '0;
        busy_ff <= 1'b1;
      end else if (busy_ff) begin
        st_ff  <= mix(st_ff, key_ff[32*rnd_ff[2:0] +: 32] ^ {26'h000_0000, rnd_ff});
        rnd_ff <= rnd_ff + 6'h01;
        if (rnd_ff == 6'(ROUNDS - 1)) begin
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
        end
      end
    end
  end

  assign busy_o = busy_ff;
  assign done_o = done_ff;
  assign ks_o   = st_ff ^ key_ff[255:128];

endmodule : cmc_keystream

// ==== sim/cmc_stream_sink.sv ====
// Stream sink model standing behind the cipher output
`timescale 1ns/1ps
module cmc_stream_sink (
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  input  wire logic         hold_i,
  input  wire logic [127:0] data_i,
  input  wire logic         valid_i,
  output logic              ready_o
);
  logic [127:0] got_q[$];
  // Stalls whenever the bench asks it to
  assign ready_o = !hold_i;
  // Popped words kept in arrival order
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      got_q.delete();
    end else if (valid_i && ready_o) begin
      got_q.push_back(data_i);
    end
  end
endmodule : cmc_stream_sink

// ==== sim/ctr_mode_traffic_cipher_tb.sv ====
// Self-checking bench of the counter-mode traffic cipher
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module ctr_mode_traffic_cipher_tb;
  logic         clk, rstn, srst, cyc, stb, we, dvi, dro, dvo, dri, act, ack, hold;
  logic [5:0]   adr;
  logic [3:0]   sel;
  logic [31:0]  wdat, rdat, r;
  logic [127:0] din, dout, c0, c1, c2, w;
  logic [127:0] pt;
  int           fail_count, cmp_count;

  cmc_cipher #(.ROUNDS(2)) dut_u (
    .SYS_CLK_I(clk), .RESETN_I(rstn), .SOFT_RESET_I(srst), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
    .WB_DAT_O(rdat), .WB_ACK_O(ack), .DATA_I(din), .DATA_VALID_I(dvi),
    .DATA_READY_O(dro), .DATA_O(dout), .DATA_VALID_O(dvo), .DATA_READY_I(dri),
    .AES_ACTIVE_O(act));
  cmc_stream_sink sink_u (.clk_i(clk), .rstn_i(rstn), .hold_i(hold), .data_i(dout),
    .valid_i(dvo), .ready_o(dri));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic wb(input logic w_en, input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w_en;
    adr <= a[7:2];
    sel <= s;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 50) begin
      fail_count++;
      $display("wrong value at %0t: no bus answer", $time);
    end
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    wb(1'b1, a, 4'hf, d, x);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    wb(1'b0, a, 4'hf, 32'h0000_0000, q);
  endtask : rd

  task automatic load(input logic [7:0] base, input int cnt, input logic [31:0] v);
    for (int i = 0; i < cnt; i++) begin
      wr(base + 8'(4 * i), v ^ 32'(i));
    end
  endtask : load

  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      rd(8'h00, r);
      n++;
    end while (r[0] !== 1'b0 && n < 100);
    if (r[0] !== 1'b0) begin
      fail_count++;
      $display("wrong value at %0t: self-test never finished", $time);
    end
  endtask : wait_idle

  // Caller stands just after a rising edge; valid stays up for back-to-back words
  task automatic send(input logic [127:0] v);
    int n;
    n = 0;
    din <= v;
    dvi <= 1'b1;
    do begin
      @(negedge clk);
      n++;
    end while (dro !== 1'b1 && n < 200);
    if (dro !== 1'b1) begin
      fail_count++;
      $display("wrong value at %0t: input word never accepted", $time);
    end
    @(posedge clk);
  endtask : send

  task automatic take(output logic [127:0] v);
    int n;
    n = 0;
    while (sink_u.got_q.size() == 0 && n < 200) begin
      @(negedge clk);
      n++;
    end
    v = (sink_u.got_q.size() > 0) ? sink_u.got_q.pop_front() : 'x;
  endtask : take

  task automatic cipher(input logic [127:0] v, output logic [127:0] q);
    @(posedge clk);
    send(v);
    dvi <= 1'b0;
    take(q);
  endtask : cipher

  task automatic do_reset(input bit hard);
    @(posedge clk);
    if (hard) rstn <= 1'b0;
    else srst <= 1'b1;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    srst <= 1'b0;
  endtask : do_reset

  task automatic final_report;
    $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report

  initial begin
    #200000;
    fail_count++;
    final_report();
  end

  initial begin
    {rstn, srst, cyc, stb, we, dvi, hold} = '0;
    adr = '0;
    sel = '0;
    wdat = '0;
    din = '0;
    fail_count = 0;
    cmp_count = 0;
    pt = {8{16'h3c5a}};
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    rd(8'h00, r);
    `CHK(r[0], 1'b1)
    wait_idle();
    `CHK(r[29], 1'b0)
    `CHK(r[30], 1'b0)
    rd(8'h04, r);
    `CHK(r, 32'h0000_0001)
    wb(1'b1, 8'h04, 4'h0, 32'h0000_0000, r);
    rd(8'h04, r);
    `CHK(r, 32'h0000_0001)
    rd(8'h14, r);
    `CHK(r, 32'h0000_0000)
    @(negedge clk);
    `CHK(act, 1'b0)
    $display("test reset_state done");

    @(posedge clk);
    hold <= 1'b1;
    send({8{16'h1111}});
    send({8{16'h2222}});
    din <= {8{16'h3333}};
    @(negedge clk);
    `CHK(dro, 1'b0)
    @(posedge clk);
    hold <= 1'b0;
    send({8{16'h3333}});
    dvi <= 1'b0;
    for (int i = 1; i < 4; i++) begin
      take(w);
      `CHK(w, {8{16'(i * 16'h1111)}})
    end
    @(negedge clk);
    `CHK(dvo, 1'b0)
    $display("test bypass_buffer done");

    load(8'h40, 4, 32'h0bad_0001);
    wr(8'h04, 32'h0000_0000);
    wait_idle();
    `CHK(r[30], 1'b1)
    `CHK(r[29], 1'b0)
    @(negedge clk);
    `CHK(act, 1'b1)
    cipher(pt, c0);
    `CHK(c0 !== pt, 1'b1)
    load(8'h20, 8, 32'h5a5a_0000);
    rd(8'h20, r);
    `CHK(r, 32'h0000_0000)
    rd(8'h44, r);
    `CHK(r, 32'h0000_0000)
    wr(8'h04, 32'h0000_0002);
    cipher(pt, c1);
    `CHK(c1 !== c0, 1'b1)
    cipher(pt, c2);
    `CHK(c2 !== c1, 1'b1)
    rd(8'h08, r);
    `CHK(r, 32'h0000_0002)
    wr(8'h04, 32'h0000_0002);
    cipher(c1, w);
    `CHK(w, pt)
    $display("test counter_mode done");

    for (int k = 0; k < 2; k++) begin
      load(8'h20, 8, 32'h7e7e_0000);
      do_reset(k[0]);
      rd(8'h04, r);
      `CHK(r, 32'h0000_0001)
      wait_idle();
      `CHK(r[29], 1'b0)
      load(8'h40, 4, 32'h0bad_0001);
      wr(8'h04, 32'h0000_0000);
      wait_idle();
      cipher(pt, w);
      `CHK(w, c0)
    end
    $display("test key_clear done");
    final_report();
  end
endmodule : ctr_mode_traffic_cipher_tb
